/* File: crsm_pkg.sv */
// Constants, field layout and counting helpers for the counter group.
// Assumes a 100 MHz system clock and an APB register port.
package crsm_pkg;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_PRESET = 8'h04;
  localparam logic [7:0] ADDR_CAPTURE = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [15:0] CFG_RESET = 16'h0800;
  localparam int CFG_OUT_LSB = 0;
  localparam int CFG_UP_BIT = 3;
  localparam int CFG_BCD_BIT = 4;
  localparam int CFG_REPEAT_BIT = 5;
  localparam int CFG_RELOAD_BIT = 6;
  localparam int CFG_SPECIAL_BIT = 7;
  localparam int CFG_SRC_LSB = 8;
  localparam int CFG_POL_BIT = 12;
  localparam int CFG_GATE_LSB = 13;
  localparam logic [2:0] OUT_LOW = 3'h0;
  localparam logic [2:0] OUT_TC_HIGH = 3'h1;
  localparam logic [2:0] OUT_TOGGLE = 3'h2;
  localparam logic [2:0] OUT_HIZ = 3'h4;
  localparam logic [2:0] OUT_TC_LOW = 3'h5;
  localparam logic [2:0] GATE_NONE = 3'h0;
  localparam logic [2:0] GATE_SAMPLE = 3'h6;
  localparam logic [3:0] SRC_F1 = 4'h8;
  localparam logic [2:0] CMD_LOAD = 3'h1;
  localparam logic [2:0] CMD_ARM = 3'h2;
  localparam logic [2:0] CMD_LOAD_ARM = 3'h3;
  localparam logic [2:0] CMD_DISARM = 3'h4;
  localparam logic [2:0] CMD_SET_OUT = 3'h5;
  localparam logic [2:0] CMD_CLR_OUT = 3'h6;
  localparam logic [2:0] CMD_MRESET = 3'h7;
  localparam logic [15:0] TC_DOWN = 16'h0001;
  localparam logic [15:0] TC_BCD = 16'h9999;
  localparam logic [15:0] TC_BIN = 16'hFFFF;
  localparam int CLK_PERIOD_NS = 10;
  localparam int F1_PERIOD_NS = 1000;
  localparam int F1_DIV = F1_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] F1_LAST = 8'(F1_DIV - 1);

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_WAIT = 3'b010,
    RS_COUNT = 3'b100
  } crsm_run_e;

  // One count in binary or BCD, up or down
  function automatic logic [15:0] crsm_step(input logic [15:0] v,
                                            input logic up,
                                            input logic bcd);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b1;
    if (!bcd) begin
      r = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (c) begin
          if (up) begin
            c = (v[4*i+:4] == 4'h9);
            r[4*i+:4] = c ? 4'h0 : v[4*i+:4] + 4'h1;
          end else begin
            c = (v[4*i+:4] == 4'h0);
            r[4*i+:4] = c ? 4'h9 : v[4*i+:4] - 4'h1;
          end
        end
      end
    end
    return r;
  endfunction

  // Count value whose next count is terminal
  function automatic logic at_tc(input logic [15:0] v, input logic up,
                                 input logic bcd);
    return up ? (v == (bcd ? TC_BCD : TC_BIN)) : (v == TC_DOWN);
  endfunction
endpackage

/* File: crsm_edge.sv */
// Edge detector for a synchronous input, polarity selectable.
// Assumes the input is already synchronous to clk.
`timescale 1ns/100ps
module crsm_edge (
  input logic clk,
  input logic rst_n,
  input logic sig,
  input logic fall_sel,
  output logic edge_pulse
);
  logic prev_r;
  logic valid_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      prev_r <= sig;
      valid_r <= 1'b1;
    end
  end

  // First cycle after reset has no history
  assign edge_pulse = valid_r & (fall_sel ? (prev_r & ~sig) : (~prev_r & sig));
endmodule

/* File: crsm_top.sv */
// Counter group: gate-selected reload, hardware sample mode, output forms.
// Assumes APB master, synchronous gate and source inputs, one clock.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module crsm_top (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [crsm_pkg::APB_AW-1:0] paddr,
  input logic [crsm_pkg::APB_DW-1:0] pwdata,
  output logic [crsm_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic gate_in,
  input logic src_in,
  output logic out_level,
  output logic out_oe,
  output logic tc_active
);
  import crsm_pkg::*;

  logic [15:0] cfg_r;
  logic [15:0] preset_r;
  logic [15:0] capture_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] capture_nxt;
  logic [15:0] reload_val;
  logic [15:0] stepped;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic [7:0] f1_cnt_r;
  logic tc_r;
  logic tc_nxt;
  logic toggle_r;
  logic toggle_nxt;
  logic out_r;
  logic out_nxt;
  logic tc_seen_r;
  crsm_run_e st_r;
  crsm_run_e st_nxt;

  wire [2:0] out_form = cfg_r[CFG_OUT_LSB+:3];
  wire [2:0] gating = cfg_r[CFG_GATE_LSB+:3];
  wire [3:0] src_sel = cfg_r[CFG_SRC_LSB+:4];
  wire cnt_up = cfg_r[CFG_UP_BIT];
  wire cnt_bcd = cfg_r[CFG_BCD_BIT];
  wire repeat_count_bit = cfg_r[CFG_REPEAT_BIT];
  wire reload_source_bit = cfg_r[CFG_RELOAD_BIT];
  wire source_polarity_bit = cfg_r[CFG_POL_BIT];

  // APB decode
  wire acc = psel & penable;
  wire addr_ok = (paddr == ADDR_CFG) | (paddr == ADDR_PRESET) |
                 (paddr == ADDR_CAPTURE) | (paddr == ADDR_CMD) |
                 (paddr == ADDR_STATUS);
  wire wr_ok = acc & pwrite & addr_ok;
  wire cfg_we = wr_ok & (paddr == ADDR_CFG);
  wire preset_we = wr_ok & (paddr == ADDR_PRESET);
  wire capture_we = wr_ok & (paddr == ADDR_CAPTURE);
  wire cmd_we = wr_ok & (paddr == ADDR_CMD);
  wire [2:0] cmd = pwdata[2:0];
  wire cmd_load = cmd_we & ((cmd == CMD_LOAD) | (cmd == CMD_LOAD_ARM));
  wire cmd_arm = cmd_we & ((cmd == CMD_ARM) | (cmd == CMD_LOAD_ARM));
  wire cmd_disarm = cmd_we & (cmd == CMD_DISARM);
  wire cmd_mreset = cmd_we & (cmd == CMD_MRESET);

  // Mode decode
  wire gate_sel_mode = (gating == GATE_NONE) & cfg_r[CFG_SPECIAL_BIT] &
                       reload_source_bit;
  wire hardware_sample_mode = (gating == GATE_SAMPLE);

  // Source and gate edges
  logic pin_edge;
  logic gate_edge;
  crsm_edge u_src_edge (
    .clk(clk),
    .rst_n(rst_n),
    .sig(src_in),
    .fall_sel(source_polarity_bit),
    .edge_pulse(pin_edge)
  );
  crsm_edge u_gate_edge (
    .clk(clk),
    .rst_n(rst_n),
    .sig(gate_in),
    .fall_sel(1'b0),
    .edge_pulse(gate_edge)
  );

  // Internal frequency divider
  wire f1_tick = (f1_cnt_r == F1_LAST);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f1_cnt_r <= 8'h00;
    end else begin
      f1_cnt_r <= f1_tick ? 8'h00 : f1_cnt_r + 8'h01;
    end
  end

  wire src_edge = (src_sel == SRC_F1) ? f1_tick : pin_edge;
  // Counting also advances through terminal count when disarmed
  wire step = src_edge & ((st_r == RS_COUNT) | tc_r);
  wire hit = at_tc(cnt_r, cnt_up, cnt_bcd);
  wire tc_ev = step & hit;

  // Gate level picks the reload register only here
  assign reload_val = (gate_sel_mode & gate_in) ? capture_r
                                                : preset_r;
  assign stepped = crsm_step(cnt_r, cnt_up, cnt_bcd);

  // Run state
  always_comb begin
    st_nxt = st_r;
    if (cmd_mreset | cmd_disarm) begin
      st_nxt = RS_IDLE;
    end else if (cmd_arm) begin
      st_nxt = hardware_sample_mode ? RS_WAIT : RS_COUNT;
    end else if (hardware_sample_mode & (st_r == RS_WAIT) & gate_edge) begin
      st_nxt = RS_COUNT;
    end else if (tc_ev & (st_r == RS_COUNT)) begin
      if (hardware_sample_mode) begin
        st_nxt = RS_WAIT;
      end else if (!repeat_count_bit) begin
        // Gate-select once mode runs two terminal counts
        if (!gate_sel_mode | tc_seen_r) begin
          st_nxt = RS_IDLE;
        end
      end
    end
  end

  // Counter and terminal count
  always_comb begin
    cnt_nxt = cnt_r;
    tc_nxt = tc_r;
    if (cmd_mreset) begin
      tc_nxt = 1'b0;
    end else if (cmd_load) begin
      cnt_nxt = reload_val;
      tc_nxt = 1'b0;
    end else if (tc_ev) begin
      cnt_nxt = reload_val;
      tc_nxt = 1'b1;
    end else if (step) begin
      cnt_nxt = stepped;
      tc_nxt = 1'b0;
    end
  end

  // Gate capture wins over a host write
  assign capture_nxt = (hardware_sample_mode & (st_r == RS_COUNT) & gate_edge)
                       ? cnt_r : (capture_we ? pwdata[15:0] : capture_r);

  always_comb begin
    toggle_nxt = toggle_r;
    if (cmd_we & (cmd == CMD_SET_OUT)) begin
      toggle_nxt = 1'b1;
    end else if (cmd_we & (cmd == CMD_CLR_OUT)) begin
      toggle_nxt = 1'b0;
    end else if (tc_r & step & ~hit) begin
      toggle_nxt = ~toggle_r;
    end
  end

  always_comb begin
    case (out_form)
      OUT_TC_HIGH: out_nxt = tc_nxt;
      OUT_TC_LOW: out_nxt = ~tc_nxt;
      OUT_TOGGLE: out_nxt = toggle_nxt;
      default: out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n | cmd_mreset) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_we) begin
      cfg_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= RS_IDLE;
      cnt_r <= 16'h0000;
      tc_r <= 1'b0;
      toggle_r <= 1'b0;
      out_r <= 1'b0;
      tc_seen_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tc_r <= tc_nxt;
      toggle_r <= toggle_nxt;
      out_r <= out_nxt;
      tc_seen_r <= cmd_arm ? 1'b0 : (tc_seen_r | (tc_ev & gate_sel_mode));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preset_r <= 16'h0000;
      capture_r <= 16'h0000;
    end else begin
      capture_r <= capture_nxt;
      if (preset_we) begin
        preset_r <= pwdata[15:0];
      end
    end
  end

  // Read data captured in the setup phase
  always_comb begin
    case (paddr)
      ADDR_CFG: rd_mux = {16'h0000, cfg_r};
      ADDR_PRESET: rd_mux = {16'h0000, preset_r};
      ADDR_CAPTURE: rd_mux = {16'h0000, capture_r};
      ADDR_STATUS: rd_mux = {12'h000, toggle_r, tc_r, st_r == RS_COUNT,
                             st_r != RS_IDLE, cnt_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign out_level = out_r;
  assign out_oe = (out_form != OUT_HIZ);
  assign tc_active = tc_r;

  chk_fsk_reload: assert property (@(posedge clk) disable iff (!rst_n)
    tc_ev & gate_sel_mode & gate_in & ~cmd_we |=> cnt_r == $past(capture_r))
    else $error("Gate-high reload did not use capture store");

  chk_gate_no_start: assert property (@(posedge clk) disable iff (!rst_n)
    gate_sel_mode & (st_r == RS_IDLE) & gate_edge & ~cmd_we |=> st_r == RS_IDLE)
    else $error("Gate edge started a gate-select counter");

  chk_fsk_repeat: assert property (@(posedge clk) disable iff (!rst_n)
    gate_sel_mode & repeat_count_bit & tc_ev & (st_r == RS_COUNT) & ~cmd_we
    |=> st_r == RS_COUNT)
    else $error("Repeating gate-select counter stopped at terminal count");

  chk_sample_trigger: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & gate_edge & ~cmd_we
    |=> (st_r == RS_IDLE) == ($past(st_r) == RS_IDLE))
    else $error("Gate edge handled wrongly in sample mode");

  chk_sample_capture: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & (st_r == RS_COUNT) & gate_edge & ~step & ~cmd_we
    |=> capture_r == $past(cnt_r) && cnt_r == $past(cnt_r))
    else $error("Gate edge did not sample count cleanly");

  chk_sample_stop: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & tc_ev & (st_r == RS_COUNT) & ~cmd_we
    |=> st_r == RS_WAIT && cnt_r == $past(preset_r))
    else $error("Sample mode did not reload and stop at terminal count");

  chk_reset_cfg: assert property (@(posedge clk)
    !rst_n |=> cfg_r == CFG_RESET)
    else $error("Configuration not at reset value");

  chk_tc_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    tc_r & step & ~hit & ~cmd_we |=> !tc_r)
    else $error("Terminal count outlasted one source period");

  chk_tc_reload: assert property (@(posedge clk) disable iff (!rst_n)
    tc_ev & ~cmd_we |=> tc_r && cnt_r == $past(reload_val))
    else $error("Terminal count without reload");

  chk_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n)
    tc_r & step & ~hit & ~cmd_we |=> toggle_r != $past(toggle_r))
    else $error("Toggle output missed trailing edge of terminal count");

  chk_sample_start: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & (st_r == RS_WAIT) & gate_edge & ~cmd_we
    |=> st_r == RS_COUNT)
    else $error("Armed sample counter ignored its trigger edge");

  chk_sample_count: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & (st_r == RS_COUNT) & src_edge & ~hit & ~cmd_we
    |=> cnt_r != $past(cnt_r))
    else $error("Sample counter skipped a source edge");

  chk_sample_hold: assert property (@(posedge clk) disable iff (!rst_n)
    hardware_sample_mode & (st_r == RS_WAIT) & ~tc_r & ~cmd_we
    |=> cnt_r == $past(cnt_r))
    else $error("Stopped sample counter moved before its trigger");

  chk_fsk_preset: assert property (@(posedge clk) disable iff (!rst_n)
    tc_ev & gate_sel_mode & ~gate_in & ~cmd_we |=> cnt_r == $past(preset_r))
    else $error("Gate-low reload did not use preset store");

  chk_gate_no_pause: assert property (@(posedge clk) disable iff (!rst_n)
    gate_sel_mode & (st_r == RS_COUNT) & src_edge & ~hit & ~cmd_we
    |=> cnt_r != $past(cnt_r))
    else $error("Gate level suspended a gate-select counter");

  chk_once_disarm: assert property (@(posedge clk) disable iff (!rst_n)
    tc_ev & (st_r == RS_COUNT) & ~repeat_count_bit & ~gate_sel_mode &
    ~hardware_sample_mode & ~cmd_we |=> st_r == RS_IDLE)
    else $error("Single-cycle counter stayed armed after terminal count");

  chk_plain_reload: assert property (@(posedge clk) disable iff (!rst_n)
    tc_ev & ~reload_source_bit & ~cmd_we |=> cnt_r == $past(preset_r))
    else $error("Reload did not use preset store");

  chk_down_tc: assert property (@(posedge clk) disable iff (!rst_n)
    step & ~cnt_up & (cnt_r == TC_DOWN) & ~cmd_we |=> tc_r)
    else $error("Down count from one missed terminal count");

  chk_mreset_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_mreset |=> cfg_r == CFG_RESET)
    else $error("Master reset did not restore configuration");

  chk_set_out: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_we & (cmd == CMD_SET_OUT) |=> toggle_r)
    else $error("Set output command did not force toggle high");

  chk_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    out_form == OUT_LOW |=> !out_level)
    else $error("Driven-low output form showed a high level");
endmodule

/* File: crsm_ext_model.sv */
// Far-side model: gate and count-source signals for the counter.
// Assumes the counter samples both pins on rising clk edges.
`timescale 1ns/100ps
module crsm_ext_model (
  input logic clk,
  output logic gate_in,
  output logic src_in
);
  initial begin
    gate_in = 1'b0;
    src_in = 1'b0;
  end
  // Gate level change, held long enough to be seen
  task automatic set_gate(input logic v);
    @(posedge clk);
    gate_in <= v;
    repeat (3) @(posedge clk);
  endtask
  // Single level change on the count source
  task automatic set_src(input logic v);
    @(posedge clk);
    src_in <= v;
    repeat (3) @(posedge clk);
  endtask
  // Whole source periods, rising then falling
  task automatic pulse_src(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      src_in <= 1'b1;
      repeat (3) @(posedge clk);
      src_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

/* File: crsm_top_tb.sv */
// Self-checking bench for the counter group over APB.
// Assumes crsm_pkg and crsm_ext_model are compiled first.
`timescale 1ns/100ps
module crsm_top_tb;
  import crsm_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic gate_in, src_in, out_level, out_oe, tc_active;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [15:0] cf [4] = '{16'h0029, 16'h003D, 16'h0021, 16'h0000};
  logic [15:0] pr [4] = '{16'hFFFE, 16'h9998, 16'h0002, 16'h0002};
  logic [15:0] pre [4] = '{16'hFFFF, 16'h9999, 16'h0001, 16'h0001};
  logic am [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int n_fail, compares, n;

  crsm_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_in(gate_in),
    .src_in(src_in), .out_level(out_level), .out_oe(out_oe),
    .tc_active(tc_active));
  crsm_ext_model EXT (.clk(clk), .gate_in(gate_in), .src_in(src_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer: setup, access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      i++;
      if (i > 20) begin
        n_fail++;
        stop_test();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic cmd(input logic [2:0] c);
    wr(ADDR_CMD, {29'h0, c});
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask

  // Armed flag and count from the status word
  task automatic st(input logic arm, input logic [15:0] cnt);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", {15'h0, rd[16:0]}, {15'h0, arm, cnt});
  endtask

  // Cycles until tc_active shows v, bounded
  task automatic wait_tc(input logic v, output int c);
    c = 0;
    while (tc_active !== v) begin
      @(posedge clk);
      c++;
      if (c > 400) begin
        n_fail++;
        stop_test();
      end
    end
  endtask

  initial begin
    #500000;
    n_fail++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state and register map
    rd_chk("cfg", ADDR_CFG, 32'h0000_0800);
    check("oe", out_oe, 32'h1);
    check("out", out_level, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", err, 32'h1);
    check("unmapped", rd, 32'h0);
    wr(ADDR_PRESET, 32'hFFFF_ABCD);
    rd_chk("preset", ADDR_PRESET, 32'h0000_ABCD);
    wr(ADDR_CFG, 32'h0000_0004);
    rd_chk("cfg", ADDR_CFG, 32'h0000_0004);
    check("oe", out_oe, 32'h0);
    cmd(CMD_MRESET);
    rd_chk("cfg", ADDR_CFG, 32'h0000_0800);
    check("oe", out_oe, 32'h1);
    // Terminal count per direction, code and output form
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_DISARM);
      wr(ADDR_CFG, {16'h0, cf[k]});
      wr(ADDR_PRESET, {16'h0, pr[k]});
      cmd(CMD_LOAD_ARM);
      EXT.pulse_src(1);
      st(1'b1, pre[k]);
      EXT.pulse_src(1);
      st(am[k], pr[k]);
      check("tc", tc_active, 32'h1);
      check("out", out_level, 32'(cf[k][2:0] == OUT_TC_HIGH));
      EXT.pulse_src(1);
      check("tc", tc_active, 32'h0);
      check("out", out_level, 32'(cf[k][2:0] == OUT_TC_LOW));
      st(am[k], pre[k]);
    end
    // Hardware sample mode
    cmd(CMD_DISARM);
    wr(ADDR_CFG, 32'h0000_C000);
    wr(ADDR_PRESET, 32'h0000_0005);
    cmd(CMD_LOAD);
    EXT.set_gate(1'b1);
    EXT.set_gate(1'b0);
    EXT.pulse_src(1);
    st(1'b0, 16'h0005);
    cmd(CMD_ARM);
    EXT.pulse_src(1);
    st(1'b1, 16'h0005);
    EXT.set_gate(1'b1);
    EXT.pulse_src(2);
    st(1'b1, 16'h0003);
    EXT.set_gate(1'b0);
    EXT.pulse_src(1);
    st(1'b1, 16'h0002);
    EXT.set_gate(1'b1);
    rd_chk("capture", ADDR_CAPTURE, 32'h0000_0002);
    EXT.pulse_src(1);
    st(1'b1, 16'h0001);
    EXT.pulse_src(1);
    check("tc", tc_active, 32'h1);
    st(1'b1, 16'h0005);
    EXT.pulse_src(2);
    st(1'b1, 16'h0004);
    EXT.set_gate(1'b0);
    EXT.set_gate(1'b1);
    EXT.pulse_src(1);
    st(1'b1, 16'h0003);
    // Gate-selected reload with toggled output
    cmd(CMD_DISARM);
    wr(ADDR_CFG, 32'h0000_00E2);
    wr(ADDR_PRESET, 32'h0000_0003);
    wr(ADDR_CAPTURE, 32'h0000_0007);
    EXT.set_gate(1'b0);
    cmd(CMD_CLR_OUT);
    cmd(CMD_LOAD);
    st(1'b0, 16'h0003);
    EXT.set_gate(1'b1);
    cmd(CMD_LOAD);
    EXT.pulse_src(1);
    st(1'b0, 16'h0007);
    cmd(CMD_ARM);
    EXT.pulse_src(7);
    st(1'b1, 16'h0007);
    check("out", out_level, 32'h0);
    EXT.pulse_src(1);
    check("out", out_level, 32'h1);
    EXT.set_gate(1'b0);
    EXT.pulse_src(6);
    st(1'b1, 16'h0003);
    EXT.pulse_src(1);
    check("out", out_level, 32'h0);
    cmd(CMD_SET_OUT);
    check("out", out_level, 32'h1);
    cmd(CMD_CLR_OUT);
    check("out", out_level, 32'h0);
    cmd(CMD_DISARM);
    st(1'b0, 16'h0002);
    // Falling source edges counted when polarity bit is set
    wr(ADDR_CFG, 32'h0000_1020);
    wr(ADDR_PRESET, 32'h0000_0005);
    cmd(CMD_LOAD_ARM);
    EXT.set_src(1'b1);
    st(1'b1, 16'h0005);
    EXT.set_src(1'b0);
    st(1'b1, 16'h0004);
    // Internal tick source: terminal count lasts one tick period
    cmd(CMD_DISARM);
    wr(ADDR_CFG, 32'h0000_0821);
    wr(ADDR_PRESET, 32'h0000_0002);
    cmd(CMD_LOAD_ARM);
    wait_tc(1'b1, n);
    wait_tc(1'b0, n);
    check("tc_len", n, F1_DIV);
    stop_test();
  end
endmodule
